/* File: logic/frs_pkg.sv */
/*
 * Shared constants and types of the field-rate side channel framer.
 * Assumes byte-wide transport packets of 188 bytes starting at a sop strobe.
 */
package frs_pkg;
   typedef logic [9:0] frs_cnt_t;
   typedef logic [7:0] frs_byte_t;
   typedef logic signed [3:0] frs_sym_t;

   // Cadence: packets per field and per cadence period
   localparam frs_cnt_t FIELD_PKTS = 10'h138;
   localparam frs_cnt_t CAD_PERIOD = 10'h270;
   localparam int BLK_BITS = int'(FIELD_PKTS);

   // Side-channel block layout, msb first
   localparam logic [15:0] FRSC_SYNC = 16'hB847;
   localparam int SYNC_W = 16;
   localparam int CTL_W = 24;
   localparam int MODE_W = 24;
   localparam int RES_W = 92;
   localparam int TAIL_W = 28;
   localparam int ECC_W = 128;
   localparam int DFS_W = MODE_W + RES_W;
   localparam int DFS_MSB = BLK_BITS - 1 - SYNC_W - CTL_W;

   // Packet byte positions
   localparam frs_byte_t TEI_IDX = 8'h01;
   localparam int TEI_BIT = 7;
   localparam frs_byte_t PID_HI_IDX = 8'h01;
   localparam frs_byte_t PID_LO_IDX = 8'h02;
   localparam frs_byte_t SUBTYPE_IDX = 8'h04;
   localparam frs_byte_t TRL_FIRST = 8'hA0;
   localparam frs_byte_t TRL_LAST = 8'hA4;
   localparam frs_byte_t ECC_FIRST = 8'hA8;
   localparam frs_byte_t LAST_IDX = 8'hBB;

   // Control packet identity, values arbitrary
   localparam logic [12:0] TCP_PID_DEF = 13'h0100;
   localparam frs_byte_t TCP_SUBTYPE_DEF = 8'h5A;

   // Field sync symbol levels
   localparam frs_sym_t SYM_POS = 4'sh5;
   localparam frs_sym_t SYM_NEG = 4'shB;
endpackage

/* File: logic/frs_link_if.sv */
/*
 * Studio link between adapter and transmitter: a byte stream with valid and
 * packet start. Both ends share one clock; the link has no back-pressure.
 */
`timescale 1ns/10ps
interface frs_link_if;
   logic [7:0] data;
   logic valid;
   logic sop;

   modport adapter (output data, valid, sop);
   modport xmtr (input data, valid, sop);
endinterface

/* File: logic/frs_pkt_track.sv */
/*
 * Packet tracker: byte index of the current byte and detection of a
 * transmitter control packet by identifier and subtype.
 * Assumes sop marks byte 0 and valid qualifies every byte.
 */
`timescale 1ns/10ps
module frs_pkt_track import frs_pkg::*; #(
   parameter logic [12:0] PID = TCP_PID_DEF,
   parameter frs_byte_t SUBTYPE = TCP_SUBTYPE_DEF
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Observed stream
   input wire logic valid_i,
   input wire logic sop_i,
   input wire frs_byte_t data_i,
   // Position and identity
   output frs_byte_t idx_o,
   output logic tcp_o
);
   frs_byte_t cnt_q;
   logic [4:0] pid_hi_q;
   logic pid_ok_q;
   logic tcp_q;
   wire at_end = (idx_o == LAST_IDX);

   assign idx_o = sop_i ? 8'h00 : cnt_q;
   // Identity is known only after the subtype byte
   assign tcp_o = tcp_q && !sop_i;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_q <= 8'h00;
         pid_hi_q <= 5'h00;
         pid_ok_q <= 1'b0;
         tcp_q <= 1'b0;
      end else if (valid_i) begin
         cnt_q <= at_end ? idx_o : idx_o + 8'h01;
         if (sop_i) begin
            tcp_q <= 1'b0;
         end
         if (idx_o == PID_HI_IDX) begin
            pid_hi_q <= data_i[4:0];
         end
         if (idx_o == PID_LO_IDX) begin
            pid_ok_q <= ({pid_hi_q, data_i} == PID);
         end
         if (idx_o == SUBTYPE_IDX) begin
            tcp_q <= pid_ok_q && (data_i == SUBTYPE);
         end
      end
   end
endmodule

/* File: logic/frs_adapter.sv */
/*
 * Adapter end: fills control packets in two stages around an external
 * processing model, fills dummy bytes and spreads the side-channel block over
 * the error-indicator bit of each field's packets.
 * Assumes the model returns the stream in order and the RS parity arrives
 * with the payload on side_ecc_i.
 */
// Summary of operation
// - one side-channel bit per packet, 312 per field
// - bit rides in transport error indicator position
// - transmitter clears that bit after extraction
// - first byte msb follows the cadence point
// - last parity lsb precedes next cadence point
// - side channel sent on every link
// - transmitter emits mode and spare bits
// - odd field zero is -5, even inverted
// - changes emitted at first following sync segment
// - new mode adopted one field later
// - control data written into matching packet
// - stage one fills all but trellis/parity
// - stage two inserts trellis and parity late
// - transmitter restores default bytes bit-exact
// - stage one data broadcast unaltered
// - block carries sync segment and control data
// - dummy byte positions carry control data
// - block opens with fixed 16-bit sync word
// - 23 payload plus 16 parity bytes
// - cadence point at wrap from 623 to zero
`timescale 1ns/10ps
module frs_adapter import frs_pkg::*; #(
   parameter logic [12:0] TCP_PID = TCP_PID_DEF,
   parameter frs_byte_t TCP_SUBTYPE = TCP_SUBTYPE_DEF
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Incoming transport stream
   input wire frs_byte_t ts_data_i,
   input wire logic ts_valid_i,
   input wire logic ts_sop_i,
   // Stage one control data, looked up by byte index
   output frs_byte_t tcp_idx_o,
   input wire frs_byte_t tcp_stage1_i,
   // Dummy byte channel
   input wire logic dummy_en_i,
   input wire logic dummy_pos_i,
   input wire frs_byte_t dummy_ctl_i,
   // Processing model tap
   output frs_byte_t model_data_o,
   output logic model_valid_o,
   output logic model_sop_o,
   input wire frs_byte_t model_data_i,
   input wire logic model_valid_i,
   input wire logic model_sop_i,
   // Stage two trellis and parity data
   output frs_byte_t tcp2_idx_o,
   input wire frs_byte_t tcp_stage2_i,
   // Side-channel content
   input wire logic cad_clr_i,
   input wire logic [CTL_W-1:0] side_ctl_i,
   input wire logic [MODE_W-1:0] field_sync_mode_bits_i,
   input wire logic [RES_W-1:0] dfs_reserved_i,
   input wire logic [TAIL_W-1:0] side_tail_i,
   input wire logic [ECC_W-1:0] side_ecc_i,
   // Cadence status
   output logic cadence_point_o,
   output logic field_odd_o,
   // Studio link
   frs_link_if.adapter link
);
   frs_byte_t in_idx;
   logic in_tcp;
   frs_byte_t ret_idx;
   logic ret_tcp;

   frs_byte_t model_data_q;
   logic model_valid_q;
   logic model_sop_q;
   frs_byte_t link_data_q;
   logic link_valid_q;
   logic link_sop_q;

   frs_cnt_t cnt_q;
   frs_cnt_t cnt_nxt;
   logic cad_q;
   logic [BLK_BITS-1:0] blk_q;

   // Stage one: input side, before the model
   frs_pkt_track #(
      .PID(TCP_PID),
      .SUBTYPE(TCP_SUBTYPE)
   ) u_track_in (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .valid_i(ts_valid_i),
      .sop_i(ts_sop_i),
      .data_i(ts_data_i),
      .idx_o(in_idx),
      .tcp_o(in_tcp)
   );

   // Trellis states and parity are left at defaults for the model
   wire in_late = (in_idx >= TRL_FIRST && in_idx <= TRL_LAST) || (in_idx >= ECC_FIRST);
   wire in_fill = in_tcp && !in_late;
   wire in_dummy = dummy_en_i && dummy_pos_i;
   wire frs_byte_t stage1_byte = in_fill ? tcp_stage1_i : (in_dummy ? dummy_ctl_i : ts_data_i);

   assign tcp_idx_o = in_idx;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         model_data_q <= 8'h00;
         model_valid_q <= 1'b0;
         model_sop_q <= 1'b0;
      end else begin
         model_valid_q <= ts_valid_i;
         model_sop_q <= ts_valid_i && ts_sop_i;
         if (ts_valid_i) begin
            model_data_q <= stage1_byte;
         end
      end
   end

   assign model_data_o = model_data_q;
   assign model_valid_o = model_valid_q;
   assign model_sop_o = model_sop_q;

   // Return side: stage two and side channel
   frs_pkt_track #(
      .PID(TCP_PID),
      .SUBTYPE(TCP_SUBTYPE)
   ) u_track_ret (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .valid_i(model_valid_i),
      .sop_i(model_sop_i),
      .data_i(model_data_i),
      .idx_o(ret_idx),
      .tcp_o(ret_tcp)
   );

   assign tcp2_idx_o = ret_idx;

   wire ret_late = (ret_idx >= TRL_FIRST && ret_idx <= TRL_LAST) || (ret_idx >= ECC_FIRST);
   // Late insertion only, so stage one bytes reach the link untouched
   wire ret_fill = ret_tcp && ret_late;
   wire ret_tei = (ret_idx == TEI_IDX);
   wire ret_pkt = model_valid_i && model_sop_i;

   // Counter pair, one step per packet; wrap marks the cadence point
   wire cnt_wrap = cad_clr_i || (cnt_q == CAD_PERIOD - 10'h001);
   assign cnt_nxt = cnt_wrap ? 10'h000 : cnt_q + 10'h001;
   wire new_field = ret_pkt && (cnt_nxt == 10'h000);
   // Reload at both field starts, else the second field of a period runs empty
   wire fld_load = ret_pkt && (cnt_nxt == 10'h000 || cnt_nxt == FIELD_PKTS);

   // Full block: sync, control, sync segment bits, tail, parity
   wire logic [BLK_BITS-1:0] blk_d = {FRSC_SYNC, side_ctl_i, field_sync_mode_bits_i,
                                     dfs_reserved_i, side_tail_i, side_ecc_i};

   // Side bit is the block msb; the block shifts once per packet
   wire side_bit = blk_q[BLK_BITS-1];

   frs_byte_t ret_byte;
   always_comb begin
      ret_byte = model_data_i;
      if (ret_tei) begin
         ret_byte[TEI_BIT] = side_bit;
      end
      if (ret_fill) begin
         ret_byte = tcp_stage2_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_q <= CAD_PERIOD - 10'h001;
         cad_q <= 1'b0;
      end else begin
         cad_q <= new_field;
         if (ret_pkt) begin
            cnt_q <= cnt_nxt;
         end
      end
   end

   // Load at each field start so its first packet carries the msb
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         blk_q <= '0;
      end else if (fld_load) begin
         blk_q <= blk_d;
      end else if (model_valid_i && ret_tei) begin
         blk_q <= {blk_q[BLK_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         link_data_q <= 8'h00;
         link_valid_q <= 1'b0;
         link_sop_q <= 1'b0;
      end else begin
         link_valid_q <= model_valid_i;
         link_sop_q <= ret_pkt;
         if (model_valid_i) begin
            link_data_q <= ret_byte;
         end
      end
   end

   assign link.data = link_data_q;
   assign link.valid = link_valid_q;
   assign link.sop = link_sop_q;

   assign cadence_point_o = cad_q;
   assign field_odd_o = (cnt_q < FIELD_PKTS);
endmodule

/* File: logic/frs_xmtr.sv */
/*
 * Transmitter end: pulls the side-channel bit from each packet, clears it,
 * restores control packet defaults and maps sync segment bits to symbols.
 * Assumes cad_align_i marks the packet that the adapter counted as zero.
 */
`timescale 1ns/10ps
module frs_xmtr import frs_pkg::*; #(
   parameter logic [12:0] TCP_PID = TCP_PID_DEF,
   parameter frs_byte_t TCP_SUBTYPE = TCP_SUBTYPE_DEF
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Studio link
   frs_link_if.xmtr link,
   input wire logic cad_align_i,
   // Restored stream
   output frs_byte_t out_data_o,
   output logic out_valid_o,
   output logic out_sop_o,
   // Control packet defaults and trellis states
   output frs_byte_t tcp_idx_o,
   input wire frs_byte_t tcp_default_i,
   output frs_byte_t trl_data_o,
   output logic trl_valid_o,
   // Side channel
   output logic [BLK_BITS-1:0] side_blk_o,
   output logic side_blk_valid_o,
   output logic side_sync_ok_o,
   // Field sync segment
   output logic [MODE_W-1:0] field_sync_mode_bits_o,
   output logic [MODE_W-1:0] mode_adopt_o,
   input wire logic [6:0] dfs_sym_idx_i,
   output frs_sym_t dfs_sym_o,
   output logic field_odd_o
);
   frs_byte_t idx;
   logic transmitter_control_packet;
   frs_cnt_t cnt_q;
   logic [BLK_BITS-1:0] sh_q;
   logic [BLK_BITS-1:0] blk_q;
   logic blk_v_q;
   logic sync_ok_q;
   logic [DFS_W-1:0] new_q;
   logic [DFS_W-1:0] em_q;
   logic [DFS_W-1:0] adopt_q;
   frs_sym_t sym_q;
   frs_byte_t out_q;
   logic out_v_q;
   logic out_s_q;
   frs_byte_t trl_q;
   logic trl_v_q;

   frs_pkt_track #(
      .PID(TCP_PID),
      .SUBTYPE(TCP_SUBTYPE)
   ) u_track (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .valid_i(link.valid),
      .sop_i(link.sop),
      .data_i(link.data),
      .idx_o(idx),
      .tcp_o(transmitter_control_packet)
   );

   assign tcp_idx_o = idx;

   wire pkt = link.valid && link.sop;
   wire tei = link.valid && (idx == TEI_IDX);
   wire in_trl = transmitter_control_packet && idx >= TRL_FIRST && idx <= TRL_LAST;
   wire strip = in_trl || (transmitter_control_packet && idx >= ECC_FIRST);
   wire frs_cnt_t cnt_nxt = (cad_align_i || cnt_q == CAD_PERIOD - 10'h001) ? 10'h000 : cnt_q + 10'h001;
   // Both field starts refresh the emitted bits
   wire fld_start = pkt && (cnt_nxt == 10'h000 || cnt_nxt == FIELD_PKTS);
   wire fld_last = (cnt_q == FIELD_PKTS - 10'h001) || (cnt_q == CAD_PERIOD - 10'h001);
   wire logic [BLK_BITS-1:0] sh_d = {sh_q[BLK_BITS-2:0], link.data[TEI_BIT]};
   wire odd = (cnt_q < FIELD_PKTS);
   wire sel_bit = em_q[7'(DFS_W - 1) - dfs_sym_idx_i];

   frs_byte_t out_d;
   always_comb begin
      out_d = link.data;
      if (idx == TEI_IDX) begin
         out_d[TEI_BIT] = 1'b0;
      end
      if (strip) begin
         out_d = tcp_default_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_q <= CAD_PERIOD - 10'h001;
         sh_q <= '0;
         blk_q <= '0;
         blk_v_q <= 1'b0;
         sync_ok_q <= 1'b0;
         new_q <= '0;
      end else begin
         blk_v_q <= 1'b0;
         if (pkt) begin
            cnt_q <= cnt_nxt;
         end
         if (tei) begin
            sh_q <= sh_d;
         end
         // Block completes on the last packet of each field, counts 311 and 623
         if (tei && fld_last) begin
            blk_q <= sh_d;
            blk_v_q <= 1'b1;
            sync_ok_q <= (sh_d[BLK_BITS-1 -: SYNC_W] == FRSC_SYNC);
            if (sh_d[BLK_BITS-1 -: SYNC_W] == FRSC_SYNC) begin
               new_q <= sh_d[DFS_MSB -: DFS_W];
            end
         end
      end
   end

   // Emission lags delivery by at most one field; adoption lags emission by one
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         em_q <= '0;
         adopt_q <= '0;
         sym_q <= SYM_NEG;
      end else begin
         if (fld_start) begin
            em_q <= new_q;
            adopt_q <= em_q;
         end
         sym_q <= (sel_bit == odd) ? SYM_POS : SYM_NEG;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         out_q <= 8'h00;
         out_v_q <= 1'b0;
         out_s_q <= 1'b0;
         trl_q <= 8'h00;
         trl_v_q <= 1'b0;
      end else begin
         out_v_q <= link.valid;
         out_s_q <= pkt;
         trl_v_q <= link.valid && in_trl;
         if (link.valid) begin
            out_q <= out_d;
            trl_q <= link.data;
         end
      end
   end

   assign out_data_o = out_q;
   assign out_valid_o = out_v_q;
   assign out_sop_o = out_s_q;
   assign trl_data_o = trl_q;
   assign trl_valid_o = trl_v_q;
   assign side_blk_o = blk_q;
   assign side_blk_valid_o = blk_v_q;
   assign side_sync_ok_o = sync_ok_q;
   assign field_sync_mode_bits_o = em_q[DFS_W-1 -: MODE_W];
   assign mode_adopt_o = adopt_q[DFS_W-1 -: MODE_W];
   assign dfs_sym_o = sym_q;
   assign field_odd_o = odd;
endmodule

/* File: dv/frs_link_monitor.sv */
/*
 * Checker for the studio link: framing, side-bit handling and cadence timing.
 * Assumes one clock and the transmitter outputs wired in beside the link.
 */
`timescale 1ns/10ps
module frs_link_monitor import frs_pkg::*; (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link
   input wire logic [7:0] data,
   input wire logic valid,
   input wire logic sop,
   // Observed outputs
   input wire logic cadence_point_o,
   input wire frs_byte_t out_data_o,
   input wire logic out_valid_o,
   input wire logic out_sop_o,
   input wire logic side_blk_valid_o,
   input wire logic [MODE_W-1:0] field_sync_mode_bits_o,
   input wire logic [MODE_W-1:0] mode_adopt_o,
   input wire frs_sym_t dfs_sym_o
);
   logic [7:0] li_q;
   logic [9:0] pc_q;
   wire logic [7:0] li = sop ? 8'h00 : li_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Starts at the last count so the first packet is a cadence point
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         li_q <= 8'h00;
         pc_q <= CAD_PERIOD - 10'h001;
      end else if (valid) begin
         li_q <= li + 8'h01;
         if (sop) begin
            pc_q <= cadence_point_o ? 10'h000 : pc_q + 10'h001;
         end
      end
   end
   sequence s_link_sop;
      valid && sop;
   endsequence
   sequence s_link_b1;
      valid && !sop && li == 8'h01;
   endsequence
   a_sop_valid: assert property (sop |-> valid)
      else $error("sop without valid");
   a_out_follows: assert property (s_link_sop |=> out_sop_o && out_valid_o)
      else $error("out sop late");
   a_tei_cleared: assert property (s_link_b1 |=> out_valid_o && !out_data_o[7])
      else $error("side bit not cleared");
   a_side_bit_only: assert property (s_link_b1 |=> out_data_o[6:0] == $past(data[6:0]))
      else $error("byte one altered");
   a_cad_on_sop: assert property (cadence_point_o |-> s_link_sop)
      else $error("cadence off sop");
   a_cad_period: assert property (s_link_sop |-> cadence_point_o == (pc_q == CAD_PERIOD - 10'h001))
      else $error("cadence period wrong");
   a_blk_field_end: assert property (side_blk_valid_o |->
      $past(valid && li == 8'h01 && (pc_q == FIELD_PKTS - 10'h001 || pc_q == CAD_PERIOD - 10'h001)))
      else $error("block valid off field end");
   a_mode_on_sop: assert property (!$stable(field_sync_mode_bits_o) |-> $past(sop && valid))
      else $error("mode bits change off sop");
   a_adopt_on_sop: assert property (!$stable(mode_adopt_o) |-> $past(sop && valid))
      else $error("adopt change off sop");
   a_sym_level: assert property (dfs_sym_o == SYM_POS || dfs_sym_o == SYM_NEG)
      else $error("symbol level wrong");
endmodule

/* File: dv/tb_top.sv */
/*
 * Bench: adapter and transmitter joined by the link, model tap looped back.
 * Assumes short plain packets are accepted, to keep fields quick.
 */
`timescale 1ns/10ps
module tb_top import frs_pkg::*; ;
   localparam logic [23:0] CTL = 24'hA5C3E1;
   localparam logic [23:0] MODE1 = 24'h0F1E2D;
   localparam logic [23:0] MODE2 = 24'hF0A512;
   localparam logic [91:0] RES = {23{4'h9}};
   localparam logic [27:0] TAIL = 28'hBEEF123;
   localparam logic [127:0] ECC = {8{16'h55AA}};
   logic ref_clk_i, rst_i, ts_valid, ts_sop, d_en, d_pos;
   logic m_valid, m_sop, cad_pt, a_odd, x_valid, x_sop, trl_valid, blk_valid, sync_ok, x_odd;
   frs_byte_t ts_data, a_idx, a_idx2, x_idx, m_data, x_data, trl_data, li_q, oi_q;
   frs_byte_t lbuf [188];
   frs_byte_t obuf [188];
   frs_byte_t trl_buf [5];
   logic [MODE_W-1:0] mode_in, mode_o, adopt_o;
   logic [BLK_BITS-1:0] blk_o, rx_blk;
   logic [6:0] sym_idx;
   frs_sym_t sym_o;
   int trl_n, n_mismatch, compares;
   frs_link_if link ();
   wire logic [7:0] li = link.sop ? 8'h00 : li_q;
   wire logic [7:0] oi = x_sop ? 8'h00 : oi_q;
   frs_adapter frs_adapter_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ts_data_i(ts_data), .ts_valid_i(ts_valid),
      .ts_sop_i(ts_sop), .tcp_idx_o(a_idx), .tcp_stage1_i(a_idx ^ 8'hC3), .dummy_en_i(d_en), .dummy_pos_i(d_pos),
      .dummy_ctl_i(~a_idx), .model_data_o(m_data), .model_valid_o(m_valid), .model_sop_o(m_sop),
      .model_data_i(m_data), .model_valid_i(m_valid), .model_sop_i(m_sop), .tcp2_idx_o(a_idx2),
      .tcp_stage2_i(a_idx2 ^ 8'h3C), .cad_clr_i(1'b0), .side_ctl_i(CTL), .field_sync_mode_bits_i(mode_in),
      .dfs_reserved_i(RES), .side_tail_i(TAIL), .side_ecc_i(ECC), .cadence_point_o(cad_pt),
      .field_odd_o(a_odd), .link(link));
   frs_xmtr frs_xmtr_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .cad_align_i(cad_pt),
      .out_data_o(x_data), .out_valid_o(x_valid), .out_sop_o(x_sop), .tcp_idx_o(x_idx),
      .tcp_default_i(x_idx ^ 8'h77), .trl_data_o(trl_data), .trl_valid_o(trl_valid), .side_blk_o(blk_o),
      .side_blk_valid_o(blk_valid), .side_sync_ok_o(sync_ok), .field_sync_mode_bits_o(mode_o),
      .mode_adopt_o(adopt_o), .dfs_sym_idx_i(sym_idx), .dfs_sym_o(sym_o), .field_odd_o(x_odd));
   frs_link_monitor frs_link_monitor_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .data(link.data),
      .valid(link.valid), .sop(link.sop), .cadence_point_o(cad_pt), .out_data_o(x_data),
      .out_valid_o(x_valid), .out_sop_o(x_sop), .side_blk_valid_o(blk_valid),
      .field_sync_mode_bits_o(mode_o), .mode_adopt_o(adopt_o), .dfs_sym_o(sym_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   // Capture of link and output bytes by packet index, trellis bytes in arrival order
   always @(posedge ref_clk_i) begin
      if (link.valid) begin
         lbuf[li] <= link.data;
         li_q <= li + 8'h01;
         if (li == 8'h01) begin
            rx_blk <= {rx_blk[BLK_BITS-2:0], link.data[7]};
         end
      end
      if (x_valid) begin
         obuf[oi] <= x_data;
         oi_q <= oi + 8'h01;
      end
      if (trl_valid && trl_n < 5) begin
         trl_buf[trl_n] <= trl_data;
      end
      if (trl_valid) begin
         trl_n <= trl_n + 1;
      end
   end
   task automatic final_report();
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [311:0] exp, input logic [311:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s exp %0h got %0h", name, exp, got);
      end
   endtask
   // Input TEI set, so the link shows the side bit replacing it
   task automatic send_pkt(input int len, input logic [12:0] pid, input frs_byte_t sub, input logic dpos);
      for (int i = 0; i < len; i++) begin
         @(negedge ref_clk_i);
         ts_valid = 1'b1;
         ts_sop = (i == 0);
         d_pos = dpos && (i == 3);
         case (i)
            0: ts_data = 8'h47;
            1: ts_data = {3'h4, pid[12:8]};
            2: ts_data = pid[7:0];
            4: ts_data = sub;
            default: ts_data = 8'h11;
         endcase
      end
      @(negedge ref_clk_i);
      ts_valid = 1'b0;
      ts_sop = 1'b0;
      d_pos = 1'b0;
   endtask
   task automatic send_n(input int n);
      repeat (n) send_pkt(6, 13'h0000, 8'h00, 1'b0);
      repeat (4) @(negedge ref_clk_i);
   endtask
   task automatic chk_sym(input logic [115:0] bits, input logic odd);
      for (int i = 0; i < 116; i++) begin
         sym_idx = i[6:0];
         @(negedge ref_clk_i);
         chk("dfs_sym", (bits[115-i] == odd) ? SYM_POS : SYM_NEG, sym_o);
      end
      chk("xmtr odd", odd, x_odd);
      chk("adapter odd", odd, a_odd);
   endtask
   task automatic t_side_block();
      send_n(100);
      chk("mid odd", 1'b1, a_odd);
      send_n(212);
      chk("link block", {FRSC_SYNC, CTL, MODE1, RES, TAIL, ECC}, rx_blk);
      chk("xmtr block", {FRSC_SYNC, CTL, MODE1, RES, TAIL, ECC}, blk_o);
      chk("sync ok", 1'b1, sync_ok);
   endtask
   task automatic t_ctl_pkt();
      logic fill;
      send_pkt(188, TCP_PID_DEF, TCP_SUBTYPE_DEF, 1'b0);
      repeat (4) @(negedge ref_clk_i);
      for (int i = 5; i < 188; i++) begin
         fill = (i >= 160 && i <= 164) || i >= 168;
         chk("link tcp", fill ? 8'(i) ^ 8'h3C : 8'(i) ^ 8'hC3, lbuf[i]);
         chk("out tcp", fill ? 8'(i) ^ 8'h77 : 8'(i) ^ 8'hC3, obuf[i]);
      end
      for (int k = 0; k < 5; k++) begin
         chk("trellis", (8'hA0 + 8'(k)) ^ 8'h3C, trl_buf[k]);
      end
      chk("trellis count", 5, trl_n);
      chk("mode emitted", MODE1, mode_o);
      chk("mode adopted", 0, adopt_o);
      chk_sym({MODE1, RES}, 1'b0);
   endtask
   task automatic t_dummy();
      d_en = 1'b1;
      send_n(0);
      send_pkt(6, 13'h0000, 8'h00, 1'b1);
      d_en = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      chk("dummy byte", 8'hFC, obuf[3]);
      chk("non dummy", 8'h00, obuf[2]);
   endtask
   task automatic t_mode_change();
      send_n(310);
      chk("field two link", {FRSC_SYNC, CTL, MODE1, RES, TAIL, ECC}, rx_blk);
      chk("field two block", {FRSC_SYNC, CTL, MODE1, RES, TAIL, ECC}, blk_o);
      chk("field two sync", 1'b1, sync_ok);
      mode_in = MODE2;
      send_n(1);
      chk("adopt field", MODE1, adopt_o);
      chk_sym({MODE1, RES}, 1'b1);
      send_n(311);
      chk("emit before", MODE1, mode_o);
      send_n(1);
      chk("emit after", MODE2, mode_o);
      chk("adopt held", MODE1, adopt_o);
      send_n(312);
      chk("adopt new", MODE2, adopt_o);
   endtask
   initial begin
      rst_i = 1'b1;
      {ts_valid, ts_sop, d_en, d_pos} = 4'h0;
      ts_data = 8'h00;
      mode_in = MODE1;
      sym_idx = 7'h00;
      {li_q, oi_q} = 16'h0000;
      {trl_n, n_mismatch, compares} = 0;
      rx_blk = '0;
      repeat (3) @(negedge ref_clk_i);
      rst_i = 1'b0;
      t_side_block();
      t_ctl_pkt();
      t_dummy();
      t_mode_change();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_mismatch++;
      final_report();
   end
endmodule
